// File: include/sol_cfg.svh
`ifndef SOL_CFG_SVH
`define SOL_CFG_SVH
`define SOL_ADDR_MODE      32'h0000_0000
`define SOL_ADDR_CTRL      32'h0000_0004
`define SOL_STRAP_PULL     5'h1B
`define SOL_RESET_MS       10
`define SOL_CLK_KHZ        250000
`define SOL_RESET_CYCLES   (`SOL_RESET_MS * `SOL_CLK_KHZ)
`define SOL_SPI_FAST_KHZ   50000
`define SOL_SPI_SLOW_KHZ   12500
`define SOL_ACC_SLAVE      2'b10
`define SOL_B_PHY          0
`define SOL_B_FAST         1
`define SOL_B_ACC          2
`define SOL_B_XTAL         4
`define SOL_B_RSVD         5
`define SOL_B_PDN          0
`define SOL_B_RMII         1
`endif

// File: include/sol_pkg.sv
package sol_pkg;
   typedef enum logic [1:0] {
      SOL_SAMPLE,
      SOL_RUN,
      SOL_DOWN
   } sol_state_t;
endpackage : sol_pkg

// File: logic/sol_strap_latch.sv
`timescale 1ns/10ps
`default_nettype none
`include "sol_cfg.svh"
module sol_strap_latch (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   input  wire logic [4:0]  strap_in,
   input  wire logic [4:0]  func_out,
   output logic      [4:0]  strap_out,
   output logic      [4:0]  strap_oe,
   output logic      [4:0]  pull_en,
   output logic      [4:0]  pull_up,
   output logic             phy_role,
   output logic             spi_fast,
   output logic             spi_slave,
   output logic             access_reserved,
   output logic             xtal_25m,
   output logic             ref_clock_out_enable,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata
);
   // ------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------
   logic [4:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
   logic [4:0] filt_q, filt_d;
   always_comb begin
      s1_d = strap_in;
      s2_d = s1_q;
      s3_d = s2_q;
      // A level counts once the second and third stages agree.
      filt_d = filt_q;
      for (int i = 0; i < 5; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            filt_d[i] = s2_q[i];
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q   <= `SOL_STRAP_PULL;
         s2_q   <= `SOL_STRAP_PULL;
         s3_q   <= `SOL_STRAP_PULL;
         filt_q <= `SOL_STRAP_PULL;
      end else if (clk_en) begin
         s1_q   <= s1_d;
         s2_q   <= s2_d;
         s3_q   <= s3_d;
         filt_q <= filt_d;
      end
   end

   // ------------------------------------------------------------
   // Sample control and latch
   // ------------------------------------------------------------
   sol_pkg::sol_state_t st_q, st_d;
   logic [4:0] lat_q, lat_d;
   logic       pdn_q, pdn_d, rmii_q, rmii_d;
   logic [1:0] cnt_q, cnt_d;
   logic       wr_q, wr_d, rd_sel;
   logic [31:0] wa_q, wa_d, rdat_q, rdat_d;
   logic       capture;
   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      lat_d   = lat_q;
      capture = 1'b0;
      case (st_q)
         // Straps need three cycles to pass the synchroniser after reset.
         sol_pkg::SOL_SAMPLE: begin
            if (cnt_q == 2'd3) begin
               capture = 1'b1;
               st_d    = pdn_q ? sol_pkg::SOL_DOWN : sol_pkg::SOL_RUN;
            end else begin
               cnt_d = cnt_q + 2'd1;
            end
         end
         sol_pkg::SOL_RUN: begin
            if (pdn_q) begin
               st_d = sol_pkg::SOL_DOWN;
            end
         end
         sol_pkg::SOL_DOWN: begin
            // Pins return to inputs so the next capture sees the board.
            if (!pdn_q) begin
               st_d  = sol_pkg::SOL_SAMPLE;
               cnt_d = 2'd0;
            end
         end
         default: st_d = sol_pkg::SOL_SAMPLE;
      endcase
      // The filter's next value is taken, because the agreeing third stage
      // only reaches the filter register at this very edge.
      if (capture) begin
         lat_d = filt_d;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q  <= sol_pkg::SOL_SAMPLE;
         cnt_q <= 2'd0;
         lat_q <= `SOL_STRAP_PULL;
      end else if (clk_en) begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         lat_q <= lat_d;
      end
   end

   // ------------------------------------------------------------
   // Decoded modes and pins
   // ------------------------------------------------------------
   always_comb begin
      phy_role  = rmii_q | lat_q[`SOL_B_PHY];
      spi_fast  = lat_q[`SOL_B_FAST];
      spi_slave = lat_q[`SOL_B_ACC+1:`SOL_B_ACC] == `SOL_ACC_SLAVE;
      access_reserved = lat_q[`SOL_B_ACC+1] == 1'b0;
      // Without the reduced interface the ref option does not exist.
      xtal_25m  = lat_q[`SOL_B_XTAL] | ~rmii_q;
      ref_clock_out_enable = 1'b0;
      pull_en   = (st_q == sol_pkg::SOL_RUN) ? 5'h00 : 5'h1F;
      pull_up   = `SOL_STRAP_PULL;
      strap_oe  = ~pull_en;
      strap_out = func_out & strap_oe;
   end

   // ------------------------------------------------------------
   // AHB-Lite slave: zero wait states, always OKAY
   // ------------------------------------------------------------
   always_comb begin
      wr_d   = hsel & hready & htrans[1] & hwrite;
      wa_d   = (hsel & hready & htrans[1]) ? haddr : wa_q;
      rd_sel = hsel & hready & htrans[1] & ~hwrite;
      pdn_d  = pdn_q;
      rmii_d = rmii_q;
      rdat_d = rdat_q;
      if (wr_q && wa_q == `SOL_ADDR_CTRL) begin
         pdn_d  = hwdata[`SOL_B_PDN];
         rmii_d = hwdata[`SOL_B_RMII];
      end
      if (rd_sel) begin
         case (haddr)
            `SOL_ADDR_MODE: rdat_d = {24'h000000, 1'b0, access_reserved,
                                      2'b00, lat_q[3:0]};
            `SOL_ADDR_CTRL: rdat_d = {30'h0000_0000, rmii_q, pdn_q};
            default:        rdat_d = 32'h0000_0000;
         endcase
         if (haddr == `SOL_ADDR_MODE) begin
            rdat_d[`SOL_B_XTAL] = lat_q[`SOL_B_XTAL];
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q   <= 1'b0;
         wa_q   <= 32'h0000_0000;
         pdn_q  <= 1'b0;
         rmii_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else if (clk_en) begin
         wr_q   <= wr_d;
         wa_q   <= wa_d;
         pdn_q  <= pdn_d;
         rmii_q <= rmii_d;
         rdat_q <= rdat_d;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdat_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence run_seen;
      st_q == sol_pkg::SOL_RUN;
   endsequence
   a_latch_hold_run: assert property (@(posedge clk) disable iff (rst)
      run_seen ##1 run_seen |-> $stable(lat_q))
      else $error("latched straps changed in run");
   a_capture_value: assert property (@(posedge clk) disable iff (rst)
      (clk_en && capture) |=> lat_q == filt_q)
      else $error("capture missed strap level");
   a_pins_input_reset: assert property (@(posedge clk) disable iff (rst)
      st_q != sol_pkg::SOL_RUN |-> strap_oe == 5'h00)
      else $error("strap pin driven during sampling");
   a_pins_output_run: assert property (@(posedge clk) disable iff (rst)
      run_seen |-> strap_oe == 5'h1F && pull_en == 5'h00)
      else $error("strap pin not output in run");
   a_phy_role: assert property (@(posedge clk) disable iff (rst)
      !rmii_q |-> phy_role == lat_q[`SOL_B_PHY])
      else $error("role decode wrong");
   a_rmii_role: assert property (@(posedge clk) disable iff (rst)
      rmii_q |-> phy_role)
      else $error("role strap used in reduced mode");
   a_spi_speed: assert property (@(posedge clk) disable iff (rst)
      spi_fast == lat_q[`SOL_B_FAST])
      else $error("serial speed decode wrong");
   a_access_code: assert property (@(posedge clk) disable iff (rst)
      spi_slave |-> !access_reserved && lat_q[3:2] == 2'b10)
      else $error("access code decode wrong");
   a_clock_select: assert property (@(posedge clk) disable iff (rst)
      !xtal_25m |-> rmii_q && !lat_q[`SOL_B_XTAL])
      else $error("reference clock chosen illegally");
   a_recapture: assert property (@(posedge clk) disable iff (rst)
      (clk_en && st_q == sol_pkg::SOL_DOWN && !pdn_q)
      |=> st_q == sol_pkg::SOL_SAMPLE)
      else $error("no recapture after power-down");
   a_enable_freeze: assert property (@(posedge clk) disable iff (rst)
      !clk_en |=> $stable(st_q) && $stable(lat_q))
      else $error("state moved while clock enable low");
   a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
      (clk_en && wr_q && wa_q == `SOL_ADDR_CTRL)
      |=> pdn_q == $past(hwdata[`SOL_B_PDN]))
      else $error("power-down control write lost");
endmodule : sol_strap_latch
`default_nettype wire

// File: testbench/sol_board_model.sv
`timescale 1ns/10ps
`default_nettype none
module sol_board_model (
   input  wire logic       clk,
   input  wire logic [4:0] board_val,
   input  wire logic [4:0] board_en,
   input  wire logic [4:0] strap_out,
   input  wire logic [4:0] strap_oe,
   input  wire logic [4:0] pull_en,
   input  wire logic [4:0] pull_up,
   output logic      [4:0] pin
);
   logic toggle_q = 1'b0;
   always_ff @(posedge clk) begin
      toggle_q <= ~toggle_q;
   end
   // A pin that nobody drives or pulls toggles, so it is never read as a
   // steady level by luck.
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         if (strap_oe[i]) begin
            pin[i] = strap_out[i];
         end else if (board_en[i]) begin
            pin[i] = board_val[i];
         end else if (pull_en[i]) begin
            pin[i] = pull_up[i];
         end else begin
            pin[i] = toggle_q ^ i[0];
         end
      end
   end
endmodule : sol_board_model
`default_nettype wire

// File: testbench/strap_option_latch_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "sol_cfg.svh"
module strap_option_latch_bench;
   logic        clk = 1'b0, rst = 1'b1, clk_en = 1'b1, hsel = 1'b0;
   logic        hwrite = 1'b0, phy, fast, slave, rsv, xtal, hrdy, hresp;
   logic [4:0]  bval = 5'h00, ben = 5'h00, fout = 5'h15;
   logic [4:0]  pin, s_out, s_oe, p_en, p_up;
   logic        refoe;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   int          errors = 0, n_compared = 0, cyc = 0;
   always #2 clk = ~clk;
   sol_strap_latch u_sol_strap_latch (.clk(clk), .rst(rst), .clk_en(clk_en),
      .strap_in(pin), .func_out(fout), .strap_out(s_out), .strap_oe(s_oe),
      .pull_en(p_en), .pull_up(p_up), .phy_role(phy), .spi_fast(fast),
      .spi_slave(slave), .access_reserved(rsv), .xtal_25m(xtal),
      .ref_clock_out_enable(refoe), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata));
   sol_board_model u_sol_board_model (.clk(clk), .board_val(bval),
      .board_en(ben), .strap_out(s_out), .strap_oe(s_oe), .pull_en(p_en),
      .pull_up(p_up), .pin(pin));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic dec(input logic [4:0] e);
      chk({27'h0, phy, fast, slave, rsv, xtal}, {27'h0, e});
   endtask : dec
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic wait_run;
      int k;
      k = 0;
      do @(posedge clk); while (s_oe !== 5'h1F && ++k < 32);
   endtask : wait_run
   task automatic do_reset;
      rst <= 1'b1;
      // A board holds reset far longer; the latch needs only the
      // synchroniser depth, so a short hold keeps the run brief.
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      wait_run();
   endtask : do_reset
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_open;
      do_reset();
      dec(5'b11101);
      chk(s_oe, 5'h1F);
      chk(p_en, 5'h00);
      chk(s_out, fout);
      bus(1'b0, `SOL_ADDR_MODE, 32'h0);
      chk(rd[6:0], 7'h1B);
      chk({31'h0, hresp}, 32'h0);
      $display("t_open done");
   endtask : t_open
   task automatic t_down;
      bval <= 5'h1C;
      ben <= 5'h1F;
      bus(1'b1, `SOL_ADDR_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      chk(s_oe, 5'h00);
      chk(p_en, 5'h1F);
      dec(5'b11101);
      bus(1'b1, `SOL_ADDR_CTRL, 32'h0);
      wait_run();
      dec(5'b00001);
      bus(1'b0, `SOL_ADDR_MODE, 32'h0);
      chk(rd[6:0], 7'h1C);
      $display("t_down done");
   endtask : t_down
   task automatic t_hold;
      bval <= 5'h0B;
      fout <= 5'h0A;
      repeat (20) @(posedge clk);
      dec(5'b00001);
      chk(s_out, 5'h0A);
      clk_en <= 1'b0;
      bus(1'b1, `SOL_ADDR_CTRL, 32'h1);
      repeat (4) @(posedge clk);
      chk(s_oe, 5'h1F);
      clk_en <= 1'b1;
      $display("t_hold done");
   endtask : t_hold
   task automatic t_rmii;
      bval <= 5'h08;
      bus(1'b1, `SOL_ADDR_CTRL, 32'h2);
      bus(1'b1, `SOL_ADDR_CTRL, 32'h3);
      bus(1'b1, `SOL_ADDR_CTRL, 32'h2);
      wait_run();
      dec(5'b10100);
      chk({31'h0, refoe}, 32'h0);
      bus(1'b0, `SOL_ADDR_CTRL, 32'h0);
      chk(rd, 32'h2);
      bus(1'b0, 32'h10, 32'h0);
      chk(rd, 32'h0);
      $display("t_rmii done");
   endtask : t_rmii
   task automatic t_hwrst;
      bval <= 5'h1A;
      do_reset();
      dec(5'b01101);
      bus(1'b0, `SOL_ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      $display("t_hwrst done");
   endtask : t_hwrst
   task automatic end_sim;
      $display("compared=%0d errors=%0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   // The whole sequence needs well under a thousand cycles.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         errors++;
         end_sim();
      end
   end
   initial begin
      t_open();
      t_down();
      t_hold();
      t_rmii();
      t_hwrst();
      end_sim();
   end
endmodule : strap_option_latch_bench
`default_nettype wire
